//--- include/tms_pkg.sv
/*
 * Package for the touch matrix scan sequencer: matrix geometry, widths,
 * timing constants and sequencer state encodings shared by the design files.
 * Assumes a single 50 MHz system clock and no software register map.
 */
package tms_pkg;

	// ----------------------------------------------------------------
	// Matrix geometry
	// ----------------------------------------------------------------
	localparam int TMS_DRIVE_LINES = 8;
	localparam int TMS_RECV_LINES = 8;
	localparam int TMS_KEYS = 64;
	localparam int TMS_DRIVE_W = 3;
	localparam int TMS_KEY_W = 6;
	localparam logic [2:0] TMS_DRIVE_LINE_FIRST = 3'h0;
	localparam logic [2:0] TMS_DRIVE_LINE_LAST = 3'h7;

	// ----------------------------------------------------------------
	// Per-key setup widths
	// ----------------------------------------------------------------
	localparam int TMS_BURST_W = 8;
	localparam int TMS_LIMIT_W = 8;
	localparam int TMS_CONV_W = 10;
	localparam logic [7:0] TMS_LIMIT_DISABLED = 8'h00;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int TMS_CLK_MHZ = 50;
	localparam int TMS_READY_GRACE_US = 100;
	localparam int TMS_READY_GRACE_CYC = TMS_READY_GRACE_US * TMS_CLK_MHZ;
	localparam int TMS_PULSE_DIV = 8;
	localparam int TMS_SPI_MAX_KHZ = 4000;

	// ----------------------------------------------------------------
	// Sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		TMS_IDLE,
		TMS_SELECT,
		TMS_BURST,
		TMS_CONVERT,
		TMS_NEXT
	} tms_state_e;

endpackage : tms_pkg

//--- design/tms_burst_gate.sv
/*
 * One receive-line charge gate: counts drive pulses of the running burst
 * and keeps capture open only for the configured pulse count of its key.
 * Assumes pulse and start strobes come from the sequencer on the same clock.
 */
`timescale 1ns/10ps
module tms_burst_gate
	import tms_pkg::*;
#(
	parameter int BURST_W = TMS_BURST_W,
	parameter int CONV_W = TMS_CONV_W
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RESET_N,
	// Burst control from the sequencer.
	input wire logic start,
	input wire logic pulse,
	input wire logic [BURST_W-1:0] burst_pulse_count,
	// Capture state toward the sequencer.
	output logic capture,
	output logic [CONV_W-1:0] charge
);

	// Pulses still to be captured on this line.
	logic [BURST_W-1:0] left_reg, left_next;
	// Accumulated charge proxy.
	logic [CONV_W-1:0] acc_reg, acc_next;

	// ----------------------------------------------------------------
	// Next-value logic
	// ----------------------------------------------------------------
	always_comb begin
		left_next = left_reg;
		acc_next = acc_reg;
		if (start) begin
			// A new burst reloads the count and clears the charge.
			left_next = burst_pulse_count;
			acc_next = '0;
		end else if (pulse && left_reg != '0) begin
			// Only counted pulses add charge on this line.
			left_next = left_reg - 1'b1;
			acc_next = acc_reg + 1'b1;
		end
	end

	// Registers only.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			left_reg <= '0;
			acc_reg <= '0;
		end else begin
			left_reg <= left_next;
			acc_reg <= acc_next;
		end
	end

	assign capture = (left_reg != '0);
	assign charge = acc_reg;

	// A gate with pulses left must shrink by one on a pulse.
	property p_gate_count;
		@(posedge CLK) disable iff (!RESET_N)
		(pulse && !start && capture) |=> (left_reg == $past(left_reg) - 1'b1);
	endproperty
	a_gate_count: assert property (p_gate_count) else $error("gate count slip");

endmodule : tms_burst_gate

//--- design/tms_scan_sequencer.sv
/*
 * Touch matrix scan sequencer: walks drive lines first to last, bursts one
 * line at a time, gates each receive line by its key's pulse count, then
 * hands out one converted value per enabled key. Also drives handshake pins.
 * Assumes per-key setup arrives as flat buses and SPI pins are asynchronous.
 */
`timescale 1ns/10ps
module tms_scan_sequencer
	import tms_pkg::*;
#(
	parameter int GRACE_CYC = TMS_READY_GRACE_CYC,
	parameter int PULSE_DIV = TMS_PULSE_DIV
) (
	// Clock and reset.
	input wire logic CLK,
	input wire logic RESET_N,
	// Per-key setup, key k at bits [8k+7:8k].
	input wire logic [TMS_KEYS*TMS_BURST_W-1:0] BURST_PULSE_COUNT,
	input wire logic [TMS_KEYS*TMS_LIMIT_W-1:0] KEY_DETECT_INTEGRATOR_LIMIT,
	// Touch state change request from processing logic.
	input wire logic TOUCH_CHANGE,
	// SPI slave pins.
	input wire logic SCK,
	input wire logic SS_N,
	input wire logic MOSI,
	output logic MISO,
	// Drive lines.
	output logic [TMS_DRIVE_LINES-1:0] DRIVE_LINE,
	// Converted results.
	output logic RESULT_VALID,
	output logic [TMS_KEY_W-1:0] RESULT_KEY,
	output logic [TMS_CONV_W-1:0] RESULT_VALUE,
	output logic SCAN_DONE,
	// Open-drain handshake pins.
	output logic COMMS_READY_LINE_O,
	output logic COMMS_READY_LINE_OE,
	output logic CHANGE_N_O,
	output logic CHANGE_N_OE,
	// Selected SPI slave status.
	output logic SPI_SELECTED
);

	// ----------------------------------------------------------------
	// Decode helpers
	// ----------------------------------------------------------------
	// Key index from receive and drive positions.
	function automatic logic [5:0] key_of(input logic [2:0] rx, input logic [2:0] dx);
		key_of = {rx, dx};
	endfunction : key_of

	// Enabled keys: a zero integrator limit disables the key.
	logic [TMS_KEYS-1:0] key_en;
	// Drive lines that have at least one enabled key.
	logic [TMS_DRIVE_LINES-1:0] line_en;
	genvar gk, gd, gr;
	generate
		for (gk = 0; gk < TMS_KEYS; gk++) begin : g_en
			assign key_en[gk] = KEY_DETECT_INTEGRATOR_LIMIT[gk*8 +: 8] != TMS_LIMIT_DISABLED;
		end
		for (gd = 0; gd < TMS_DRIVE_LINES; gd++) begin : g_line
			logic [TMS_RECV_LINES-1:0] col;
			for (gr = 0; gr < TMS_RECV_LINES; gr++) begin : g_col
				assign col[gr] = key_en[gr*8 + gd];
			end
			assign line_en[gd] = |col;
		end
	endgenerate

	// ----------------------------------------------------------------
	// Sequencer state
	// ----------------------------------------------------------------
	tms_state_e state_reg, state_next;
	logic [2:0] drive_reg, drive_next; // Current drive line.
	logic [2:0] recv_reg, recv_next; // Receive line being converted.
	logic [7:0] div_reg, div_next; // Pulse rate divider.
	logic burst_start; // Strobe that reloads all gates.
	logic pulse_en; // One-cycle drive pulse enable.
	logic [TMS_RECV_LINES-1:0] capturing; // Gates still open.
	logic [TMS_RECV_LINES*TMS_CONV_W-1:0] charge_bus; // Gate charges.
	logic res_valid_reg, res_valid_next;
	logic [5:0] res_key_reg, res_key_next;
	logic [TMS_CONV_W-1:0] res_val_reg, res_val_next;
	logic done_reg, done_next;

	// Lowest enabled drive line at or after a start point.
	function automatic logic [3:0] next_line(input logic [7:0] en, input logic [3:0] from);
		next_line = 4'h8;
		for (int i = 7; i >= 0; i--) begin
			if (en[i] && i >= int'(from)) begin
				next_line = 4'(i);
			end
		end
	endfunction : next_line

	// Receive gates, one per line, all fed by the same burst.
	generate
		for (gr = 0; gr < TMS_RECV_LINES; gr++) begin : g_gate
			// Key under this gate on the current drive line.
			wire logic [5:0] gate_key = key_of(3'(gr), drive_reg);
			tms_burst_gate u_gate (
				.CLK(CLK),
				.RESET_N(RESET_N),
				.start(burst_start),
				.pulse(pulse_en),
				.burst_pulse_count(key_en[gate_key] ? BURST_PULSE_COUNT[gate_key*8 +: 8] : 8'h00),
				.capture(capturing[gr]),
				.charge(charge_bus[gr*TMS_CONV_W +: TMS_CONV_W])
			);
		end
	endgenerate

	assign burst_start = (state_reg == TMS_SELECT);
	assign pulse_en = (state_reg == TMS_BURST) && (div_reg == 8'(PULSE_DIV - 1));

	// Next-value logic of the scan sequencer.
	always_comb begin
		logic [3:0] nl;
		nl = 4'h0;
		state_next = state_reg;
		drive_next = drive_reg;
		recv_next = recv_reg;
		div_next = 8'h00;
		res_valid_next = 1'b0;
		res_key_next = res_key_reg;
		res_val_next = res_val_reg;
		done_next = 1'b0;
		case (state_reg)
			TMS_IDLE: begin
				// Start at the first enabled line; stay idle if none.
				nl = next_line(line_en, 4'(TMS_DRIVE_LINE_FIRST));
				if (!nl[3]) begin
					drive_next = nl[2:0];
					state_next = TMS_SELECT;
				end
			end
			TMS_SELECT: begin
				// Gates reload this cycle; pulsing begins next.
				state_next = TMS_BURST;
			end
			TMS_BURST: begin
				// Whole burst runs until every gate has closed.
				div_next = pulse_en ? 8'h00 : div_reg + 8'h01;
				if (capturing == '0) begin
					recv_next = 3'h0;
					state_next = TMS_CONVERT;
				end
			end
			TMS_CONVERT: begin
				// One result per enabled key, receive order.
				if (key_en[key_of(recv_reg, drive_reg)]) begin
					res_valid_next = 1'b1;
					res_key_next = key_of(recv_reg, drive_reg);
					res_val_next = charge_bus[recv_reg*TMS_CONV_W +: TMS_CONV_W];
				end
				recv_next = recv_reg + 3'h1;
				if (recv_reg == 3'h7) begin
					state_next = TMS_NEXT;
				end
			end
			TMS_NEXT: begin
				// Skip lines without keys; wrap after the last.
				nl = (drive_reg == TMS_DRIVE_LINE_LAST) ? 4'h8 :
					next_line(line_en, {1'b0, drive_reg} + 4'h1);
				if (nl[3]) begin
					done_next = 1'b1;
					state_next = TMS_IDLE;
				end else begin
					drive_next = nl[2:0];
					state_next = TMS_SELECT;
				end
			end
			default: state_next = TMS_IDLE;
		endcase
	end

	// Sequencer registers.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_reg <= TMS_IDLE;
			drive_reg <= 3'h0;
			recv_reg <= 3'h0;
			div_reg <= 8'h00;
			res_valid_reg <= 1'b0;
			res_key_reg <= 6'h00;
			res_val_reg <= '0;
			done_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			drive_reg <= drive_next;
			recv_reg <= recv_next;
			div_reg <= div_next;
			res_valid_reg <= res_valid_next;
			res_key_reg <= res_key_next;
			res_val_reg <= res_val_next;
			done_reg <= done_next;
		end
	end

	// Only the line under burst pulses; others stay low.
	always_comb begin
		DRIVE_LINE = '0;
		if (state_reg == TMS_BURST) begin
			DRIVE_LINE[drive_reg] = pulse_en;
		end
	end

	assign RESULT_VALID = res_valid_reg;
	assign RESULT_KEY = res_key_reg;
	assign RESULT_VALUE = res_val_reg;
	assign SCAN_DONE = done_reg;

	// ----------------------------------------------------------------
	// Handshake pins and SPI select
	// ----------------------------------------------------------------
	logic [1:0] ss_sync_reg, ss_sync_next; // Select synchroniser.
	logic [12:0] grace_reg, grace_next; // Ready delay after reset.
	logic ready_reg, ready_next;
	logic chg_reg, chg_next; // Change pending.

	// Next values for handshake state.
	always_comb begin
		ss_sync_next = {ss_sync_reg[0], SS_N};
		grace_next = grace_reg;
		ready_next = ready_reg;
		if (grace_reg != 13'(GRACE_CYC)) begin
			grace_next = grace_reg + 13'h1;
		end else begin
			ready_next = 1'b1;
		end
		// Change stays low until the host selects the slave; set wins.
		chg_next = TOUCH_CHANGE | (chg_reg & ~SPI_SELECTED);
	end

	// Handshake registers.
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			ss_sync_reg <= 2'h3;
			grace_reg <= 13'h0;
			ready_reg <= 1'b0;
			chg_reg <= 1'b0;
		end else begin
			ss_sync_reg <= ss_sync_next;
			grace_reg <= grace_next;
			ready_reg <= ready_next;
			chg_reg <= chg_next;
		end
	end

	// Slave selected once the synchronised select is low.
	assign SPI_SELECTED = ~ss_sync_reg[1];
	assign MISO = 1'b0;
	// Open drain: drive low while not ready, release high when ready.
	assign COMMS_READY_LINE_O = 1'b0;
	assign COMMS_READY_LINE_OE = ~ready_reg;
	assign CHANGE_N_O = 1'b0;
	assign CHANGE_N_OE = chg_reg;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_burst_end;
		(state_reg == TMS_BURST) && (capturing == '0);
	endsequence

	property p_drive_idle;
		@(posedge CLK) disable iff (!RESET_N)
		(line_en == '0 && state_reg == TMS_IDLE) |-> (DRIVE_LINE == '0) ##1 (state_reg == TMS_IDLE);
	endproperty
	a_drive_idle: assert property (p_drive_idle) else $error("burst with no keys");

	property p_one_hot;
		@(posedge CLK) disable iff (!RESET_N)
		$onehot0(DRIVE_LINE);
	endproperty
	a_one_hot: assert property (p_one_hot) else $error("two lines driven");

	property p_burst_line_enabled;
		@(posedge CLK) disable iff (!RESET_N)
		(state_reg == TMS_BURST) |-> line_en[drive_reg];
	endproperty
	a_burst_line_enabled: assert property (p_burst_line_enabled) else $error("empty line burst");

	property p_convert_after;
		@(posedge CLK) disable iff (!RESET_N)
		s_burst_end |=> (state_reg == TMS_CONVERT) && (recv_reg == 3'h0);
	endproperty
	a_convert_after: assert property (p_convert_after) else $error("no convert after burst");

	property p_convert_len;
		@(posedge CLK) disable iff (!RESET_N)
		s_burst_end |=> (state_reg == TMS_CONVERT) [*8] ##1 (state_reg == TMS_NEXT);
	endproperty
	a_convert_len: assert property (p_convert_len) else $error("convert length wrong");

	property p_result_enabled;
		@(posedge CLK) disable iff (!RESET_N)
		RESULT_VALID |-> key_en[RESULT_KEY] && (RESULT_KEY[2:0] == drive_reg);
	endproperty
	a_result_enabled: assert property (p_result_enabled) else $error("disabled key reported");

	property p_ascending;
		@(posedge CLK) disable iff (!RESET_N)
		(state_reg == TMS_NEXT && state_next == TMS_SELECT) |=> (drive_reg > $past(drive_reg));
	endproperty
	a_ascending: assert property (p_ascending) else $error("drive order wrong");

	property p_ready_grace;
		@(posedge CLK) disable iff (!RESET_N)
		(grace_reg != 13'(GRACE_CYC)) |-> COMMS_READY_LINE_OE;
	endproperty
	a_ready_grace: assert property (p_ready_grace) else $error("ready too early");

	property p_change_low;
		@(posedge CLK) disable iff (!RESET_N)
		TOUCH_CHANGE |=> CHANGE_N_OE;
	endproperty
	a_change_low: assert property (p_change_low) else $error("change not pulled");

endmodule : tms_scan_sequencer

//--- tb/tms_host_model.sv
/*
 * Host model on the far side of the scan sequencer: resolves the open-drain
 * ready and change pins through pull-ups, drives the SPI select and waits out
 * the grace period before it trusts the ready pin.
 * Assumes the bench clock and the bench-driven active-low reset.
 */
`timescale 1ns/10ps
module tms_host_model #(
	parameter int GRACE = 25
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic reset_n,
	// Device open-drain drivers.
	input wire logic ready_o,
	input wire logic ready_oe,
	input wire logic chg_o,
	input wire logic chg_oe,
	// Bench request to select the device.
	input wire logic sel_req,
	// SPI pins toward the device.
	output logic ss_n,
	output logic sck,
	output logic mosi,
	// Resolved pin levels and grace status.
	output logic ready_pin,
	output logic change_pin,
	output logic grace_done
);
	// Select register, idle data pattern and grace counter.
	logic sel_q = 1'b0;
	logic mosi_q = 1'b0;
	int cnt = 0;

	// Pull-ups hold each pin high unless the device pulls it low.
	assign ready_pin = ready_oe ? ready_o : 1'b1;
	assign change_pin = chg_oe ? chg_o : 1'b1;
	// Select is active low; the serial clock stands still with no frames.
	assign ss_n = ~sel_q;
	assign sck = 1'b0;
	// Unused data line toggles so a stale level is never mistaken for data.
	assign mosi = mosi_q;
	// Ready is only trusted once the grace period has run out.
	assign grace_done = (cnt >= GRACE);

	// Select follows the bench request; grace restarts with every reset.
	always @(posedge clk) begin
		sel_q <= sel_req;
		mosi_q <= ~mosi_q;
		cnt <= reset_n ? ((cnt < GRACE) ? cnt + 1 : cnt) : 0;
	end
endmodule : tms_host_model

//--- tb/test_touch_matrix_scan_sequencer.sv
/*
 * Self-checking bench for the scan sequencer: random key setups, scan order,
 * burst lengths, skipped lines, handshake pins and resets.
 * Assumes tms_pkg and the host model are compiled first.
 */
`timescale 1ns/10ps
module test_touch_matrix_scan_sequencer;
	import tms_pkg::*;
	// ----------------------------------------------------------------
	// Stimulus, observed outputs and bookkeeping
	// ----------------------------------------------------------------
	logic CLK = 1'b0;
	logic RESET_N = 1'b0;
	logic [TMS_KEYS*TMS_BURST_W-1:0] bpc = '0;
	logic [TMS_KEYS*TMS_LIMIT_W-1:0] lim = '0;
	logic touch = 1'b0;
	logic sel_req = 1'b0;
	logic ss_n, sck, mosi, rv, sd, sel, rdy_o, rdy_oe, chg_o, chg_oe, rdy_pin, chg_pin, gd;
	logic [7:0] drv;
	logic [5:0] rkey;
	logic [9:0] rval;
	logic [7:0] bc [64];
	logic [7:0] lm [64];
	int seed = 59;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;
	int per_a, per_b;

	// The clock toggles every 10 ns, a period of 20 ns.
	always #10 CLK = ~CLK;

	// Key setup tables are copied onto the flat buses at each rising edge.
	always @(posedge CLK) begin
		for (int k = 0; k < TMS_KEYS; k++) begin
			bpc[8*k+:8] <= bc[k];
			lim[8*k+:8] <= lm[k];
		end
	end

	tms_scan_sequencer #(.GRACE_CYC(20), .PULSE_DIV(2)) dut (
		.CLK(CLK), .RESET_N(RESET_N), .BURST_PULSE_COUNT(bpc),
		.KEY_DETECT_INTEGRATOR_LIMIT(lim), .TOUCH_CHANGE(touch), .SCK(sck), .SS_N(ss_n),
		.MOSI(mosi), .MISO(), .DRIVE_LINE(drv), .RESULT_VALID(rv), .RESULT_KEY(rkey),
		.RESULT_VALUE(rval), .SCAN_DONE(sd), .COMMS_READY_LINE_O(rdy_o),
		.COMMS_READY_LINE_OE(rdy_oe), .CHANGE_N_O(chg_o), .CHANGE_N_OE(chg_oe),
		.SPI_SELECTED(sel));

	tms_host_model #(.GRACE(25)) host (
		.clk(CLK), .reset_n(RESET_N), .ready_o(rdy_o), .ready_oe(rdy_oe), .chg_o(chg_o),
		.chg_oe(chg_oe), .sel_req(sel_req), .ss_n(ss_n), .sck(sck), .mosi(mosi),
		.ready_pin(rdy_pin), .change_pin(chg_pin), .grace_done(gd));

	// ----------------------------------------------------------------
	// Checking helpers
	// ----------------------------------------------------------------
	// Counts one comparison and reports it at once if it failed.
	task automatic check(input logic ok, input string msg);
		samples_checked++;
		if (ok !== 1'b1) begin
			mismatches++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask : check

	// Expected pulses on a drive line: longest burst among its enabled keys.
	function automatic logic [7:0] line_max(input int d);
		line_max = 8'h00;
		for (int r = 0; r < 8; r++)
			if (lm[8*r+d] != 8'h00 && bc[8*r+d] > line_max)
				line_max = bc[8*r+d];
	endfunction : line_max

	// Random setup; lines 0 and 4 always hold an enabled key.
	task automatic rand_cfg(input int it);
		logic [7:0] m;
		m = 8'($random(seed)) | 8'h11;
		if (it == 0)
			m = 8'hff;
		foreach (bc[k]) begin
			bc[k] = 8'($random(seed)) & 8'h1f;
			lm[k] = m[k%8] ? ((it == 0) ? 8'h01 : 8'($random(seed)) & 8'h03) : 8'h00;
		end
		bc[63] = (it == 0) ? 8'hff : bc[63];
		lm[0] = 8'h02;
		lm[4] = 8'h02;
	endtask : rand_cfg

	// Follows one scan up to its done pulse; optionally checks it in full.
	task automatic scan(input bit chk, output int len);
		int n;
		int p [8];
		logic [15:0] q [$];
		n = 0;
		foreach (p[d])
			p[d] = 0;
		do begin
			@(negedge CLK);
			n++;
			if (rv === 1'b1)
				q.push_back({rkey, rval});
			for (int d = 0; d < 8; d++)
				p[d] += int'(drv[d]);
			if (chk && $countones(drv) > 1)
				check(1'b0, "two drive lines at once");
		end while (sd !== 1'b1 && n < 9000);
		len = n;
		check(sd === 1'b1, "scan did not complete");
		if (!chk)
			return;
		for (int d = 0; d < 8; d++) begin
			check(p[d] == int'(line_max(d)), "drive pulses on line");
			for (int r = 0; r < 8; r++)
				if (lm[8*r+d] != 8'h00)
					check(q.size() > 0 && q.pop_front() === {6'(8*r+d), 2'b00, bc[8*r+d]},
						"result key or value");
		end
		check(q.size() == 0, "result from disabled key");
	endtask : scan

	// Prints the counts and the verdict, then ends the run.
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : close_out

	// Cuts a hang short well above the expected run length.
	always @(posedge CLK) begin
		cycles <= cycles + 1;
		if (cycles == 60000) begin
			mismatches++;
			close_out();
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		foreach (bc[k]) begin
			bc[k] = 8'h00;
			lm[k] = 8'h00;
		end
		repeat (20) @(posedge CLK);
		RESET_N <= 1'b1;
		@(negedge CLK);
		check(rdy_pin === 1'b0, "ready before grace");
		// With every key disabled the drive lines must stay quiet.
		repeat (300) begin
			@(negedge CLK);
			if (drv !== 8'h00 || rv !== 1'b0 || sd !== 1'b0)
				check(1'b0, "activity with no key enabled");
		end
		check(gd === 1'b1 && rdy_pin === 1'b1, "ready after grace");
		// A touch change pulls the pin low until the host selects the device.
		@(posedge CLK) touch <= 1'b1;
		@(posedge CLK) touch <= 1'b0;
		repeat (3) @(negedge CLK);
		check(chg_pin === 1'b0, "change pin not low");
		@(posedge CLK) sel_req <= 1'b1;
		repeat (5) @(negedge CLK);
		check(sel === 1'b1 && chg_pin === 1'b1, "select or change release");
		@(posedge CLK) sel_req <= 1'b0;
		// Random setups, the first with every key enabled.
		for (int it = 0; it < 6; it++) begin
			@(posedge CLK);
			rand_cfg(it);
			repeat (2) scan(1'b0, per_a);
			scan(1'b1, per_a);
		end
		// Dropping drive line 4 must shorten the scan.
		@(posedge CLK);
		for (int r = 0; r < 8; r++)
			lm[8*r+4] = 8'h00;
		repeat (2) scan(1'b0, per_b);
		scan(1'b1, per_b);
		check(per_b < per_a, "scan not shorter");
		// Reset just after a scan ends, then a full scan from the first line.
		@(posedge CLK) RESET_N <= 1'b0;
		@(negedge CLK);
		check(drv === 8'h00 && rv === 1'b0 && rdy_pin === 1'b0, "outputs in reset");
		@(posedge CLK) RESET_N <= 1'b1;
		scan(1'b1, per_b);
		close_out();
	end
endmodule : test_touch_matrix_scan_sequencer
